// ==== rtl/gpio_ports_cde.sv ====
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_cde
    import gpio_pkg::*;
(
    // clock, reset, enable
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        CE,
    // wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // port C pads
    input  wire logic [5:0]  C_PAD_IN,
    output logic      [5:0]  C_PAD_OUT,
    output logic      [5:0]  C_PAD_OE_N,
    // port D pads
    input  wire logic [7:0]  D_PAD_IN,
    output logic      [7:0]  D_PAD_OUT,
    output logic      [7:0]  D_PAD_OE_N,
    // port E pads
    input  wire logic [7:0]  E_PAD_IN,
    output logic      [7:0]  E_PAD_OUT,
    output logic      [7:0]  E_PAD_OE_N,
    // peripheral drive
    input  wire logic        SPI_SCK_OUT,
    input  wire logic        SPI_MOSI_OUT,
    input  wire logic        SPI_MISO_OUT,
    input  wire logic [1:0]  TIMER_A_CH_OUT,
    input  wire logic [1:0]  TIMER_A_CH_OE,
    input  wire logic        SERIAL_TX_OUT
);

////////////////////////////////////////////////////////////////////////////
    logic [5:0] port_c_pin_latch;
    logic [5:0] port_c_direction;
    logic       clock_out_enable;
    logic [7:0] port_d_pin_latch;
    logic [7:0] port_d_direction;
    logic [7:0] port_e_pin_latch;
    logic [7:0] port_e_direction;
    logic [4:0] converter_channel_select;
    logic [7:0] prescaler_select;
    logic [3:0] serial_ctl;
    logic [3:0] edge_level_select;
    logic       mclk;

    logic       req;
    logic       wr;
    logic [5:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;

    assign req   = WB_CYC_I & WB_STB_I;
    assign idx   = WB_ADR_I[7:2];
    assign wbyte = WB_DAT_I[7:0];
    // write lands on the edge the master samples ack
    assign wr = CE & req & WB_WE_I & WB_ACK_O & WB_SEL_I[0];

////////////////////////////////////////////////////////////////////////////
    logic [5:0] c_own;
    logic [5:0] c_pout;
    logic [7:0] d_own;
    logic [7:0] e_own;
    logic [7:0] e_poe;
    logic [7:0] e_pout;

    port_owner_decode u_owner (
        .conv_sel   (converter_channel_select),
        .presc      (prescaler_select),
        .ser_ctl    (serial_ctl),
        .els        (edge_level_select),
        .clk_out_en (clock_out_enable),
        .mclk       (mclk),
        .sck_out    (SPI_SCK_OUT),
        .mosi_out   (SPI_MOSI_OUT),
        .miso_out   (SPI_MISO_OUT),
        .tch_out    (TIMER_A_CH_OUT),
        .tch_oe     (TIMER_A_CH_OE),
        .tx_out     (SERIAL_TX_OUT),
        .c_own      (c_own),
        .c_pout     (c_pout),
        .d_own      (d_own),
        .e_own      (e_own),
        .e_poe      (e_poe),
        .e_pout     (e_pout)
    );

    logic [5:0] c_rd;
    logic [5:0] c_drv;
    logic [5:0] c_oen;
    logic [5:0] c_read;
    logic [7:0] d_rd;
    logic [7:0] d_drv;
    logic [7:0] d_oen;
    logic [7:0] e_rd;
    logic [7:0] e_drv;
    logic [7:0] e_oen;

    port_pin_mux #(.W(PC_W)) u_mux_c (
        .latch (port_c_pin_latch),
        .dir   (port_c_direction),
        .own   (c_own),
        .poe   (c_own),
        .pout  (c_pout),
        .zero  (6'h00),
        .pin   (C_PAD_IN),
        .rd    (c_rd),
        .drv   (c_drv),
        .oe_n  (c_oen)
    );

    // converter and timer clock pins share one mask: input reads 0
    port_pin_mux #(.W(PORT_W)) u_mux_d (
        .latch (port_d_pin_latch),
        .dir   (port_d_direction),
        .own   (d_own),
        .poe   (8'h00),
        .pout  (8'h00),
        .zero  (d_own),
        .pin   (D_PAD_IN),
        .rd    (d_rd),
        .drv   (d_drv),
        .oe_n  (d_oen)
    );

    port_pin_mux #(.W(PORT_W)) u_mux_e (
        .latch (port_e_pin_latch),
        .dir   (port_e_direction),
        .own   (e_own),
        .poe   (e_poe),
        .pout  (e_pout),
        .zero  (8'h00),
        .pin   (E_PAD_IN),
        .rd    (e_rd),
        .drv   (e_drv),
        .oe_n  (e_oen)
    );

    always_comb begin
        c_read = c_rd;
        c_read[MCLK_PIN] = c_rd[MCLK_PIN] & ~clock_out_enable;
    end

////////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (idx)
            IDX_C_DATA:  rd_byte = {2'b00, c_read};
            IDX_D_DATA:  rd_byte = d_rd;
            IDX_C_DIR:   rd_byte = {clock_out_enable, 1'b0,
                                    port_c_direction};
            IDX_D_DIR:   rd_byte = port_d_direction;
            IDX_E_DATA:  rd_byte = e_rd;
            IDX_E_DIR:   rd_byte = port_e_direction;
            IDX_CONV:    rd_byte = {3'b000, converter_channel_select};
            IDX_PRESCL:  rd_byte = prescaler_select;
            IDX_SER_CTL: rd_byte = {4'h0, serial_ctl};
            IDX_ELS:     rd_byte = {4'h0, edge_level_select};
            default:     rd_byte = RST_BYTE;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= RST_WORD;
        end else if (CE) begin
            WB_ACK_O <= req & ~WB_ACK_O;
            if (req & ~WB_ACK_O) begin
                WB_DAT_O <= {24'h000000, rd_byte};
            end
        end
    end

    // latches take any write regardless of direction
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            port_c_pin_latch <= RST_BYTE[5:0];
            port_d_pin_latch <= RST_BYTE;
            port_e_pin_latch <= RST_BYTE;
        end else if (wr) begin
            if (idx == IDX_C_DATA) begin
                port_c_pin_latch <= wbyte[5:0];
            end
            if (idx == IDX_D_DATA) begin
                port_d_pin_latch <= wbyte;
            end
            if (idx == IDX_E_DATA) begin
                port_e_pin_latch <= wbyte;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            port_c_direction <= RST_BYTE[5:0];
            clock_out_enable <= 1'b0;
            port_d_direction <= RST_BYTE;
            port_e_direction <= RST_BYTE;
        end else if (wr) begin
            if (idx == IDX_C_DIR) begin
                port_c_direction <= wbyte[5:0];
                clock_out_enable <= wbyte[CLK_OUT_BIT];
            end
            if (idx == IDX_D_DIR) begin
                port_d_direction <= wbyte;
            end
            if (idx == IDX_E_DIR) begin
                port_e_direction <= wbyte;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            converter_channel_select <= RST_BYTE[4:0];
            prescaler_select <= RST_BYTE;
            serial_ctl <= RST_BYTE[3:0];
            edge_level_select <= RST_BYTE[3:0];
        end else if (wr) begin
            if (idx == IDX_CONV) begin
                converter_channel_select <= wbyte[4:0];
            end
            if (idx == IDX_PRESCL) begin
                prescaler_select <= wbyte;
            end
            if (idx == IDX_SER_CTL) begin
                serial_ctl <= wbyte[3:0];
            end
            if (idx == IDX_ELS) begin
                edge_level_select <= wbyte[3:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////
    // pad outputs must leave a flop, so the clock out is REF_CLK / 2
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mclk <= 1'b0;
        end else if (CE) begin
            mclk <= ~mclk;
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            C_PAD_OUT  <= RST_BYTE[5:0];
            C_PAD_OE_N <= RST_OE_N[5:0];
            D_PAD_OUT  <= RST_BYTE;
            D_PAD_OE_N <= RST_OE_N;
            E_PAD_OUT  <= RST_BYTE;
            E_PAD_OE_N <= RST_OE_N;
        end else if (CE) begin
            C_PAD_OUT  <= c_drv;
            C_PAD_OE_N <= c_oen;
            D_PAD_OUT  <= d_drv;
            D_PAD_OE_N <= d_oen;
            E_PAD_OUT  <= e_drv;
            E_PAD_OE_N <= e_oen;
        end
    end

////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);

    logic rd_take;
    assign rd_take = CE & req & ~WB_ACK_O & ~WB_WE_I;

    property p_c_dir_reset;
        $past(SYS_RST) |-> port_c_direction == 6'h00 && !clock_out_enable;
    endproperty
    a_c_dir_reset: assert property (p_c_dir_reset)
        else $error("port C direction not cleared by reset");

    property p_d_dir_reset;
        $past(SYS_RST) |-> D_PAD_OE_N == 8'hff && port_d_direction == 8'h00;
    endproperty
    a_d_dir_reset: assert property (p_d_dir_reset)
        else $error("port D not all inputs after reset");

    property p_c_read_pin;
        rd_take && idx == IDX_C_DATA && !port_c_direction[0]
            |=> WB_DAT_O[0] == $past(C_PAD_IN[0]);
    endproperty
    a_c_read_pin: assert property (p_c_read_pin)
        else $error("port C input read not pin level");

    property p_latch_write;
        wr && idx == IDX_D_DATA && port_d_direction == 8'h00
            |=> port_d_pin_latch == $past(wbyte) && D_PAD_OE_N == 8'hff;
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("latch write lost or pin driven");

    property p_clk_out;
        // a write may switch the clock off in between; no toggle owed then
        CE && clock_out_enable |=> !C_PAD_OE_N[MCLK_PIN] ##1
            (!CE || !clock_out_enable
             || C_PAD_OUT[MCLK_PIN] != $past(C_PAD_OUT[MCLK_PIN]));
    endproperty
    a_clk_out: assert property (p_clk_out)
        else $error("clock out not driven on C pin 2");

    property p_clk_read_zero;
        rd_take && idx == IDX_C_DATA && clock_out_enable
            |=> WB_DAT_O[MCLK_PIN] == 1'b0;
    endproperty
    a_clk_read_zero: assert property (p_clk_read_zero)
        else $error("C pin 2 reads nonzero under clock out");

    property p_d_read_latch;
        rd_take && idx == IDX_D_DATA && port_d_direction[3]
            |=> WB_DAT_O[3] == $past(port_d_pin_latch[3]);
    endproperty
    a_d_read_latch: assert property (p_d_read_latch)
        else $error("port D output read not latch");

    property p_conv_zero;
        rd_take && idx == IDX_D_DATA && converter_channel_select == 5'h08
            && !port_d_direction[0] |=> WB_DAT_O[0] == 1'b0;
    endproperty
    a_conv_zero: assert property (p_conv_zero)
        else $error("converter channel input read not zero");

    property p_ext_clk_input;
        CE && prescaler_select[2:0] == PS_EXT_CLK
            |=> D_PAD_OE_N[TIMER_A_CLK_PIN];
    endproperty
    a_ext_clk_input: assert property (p_ext_clk_input)
        else $error("timer A clock pin driven");

    property p_spi_master;
        CE && serial_ctl[SPI_EN_BIT] && serial_ctl[MSTR_BIT]
            |=> !E_PAD_OE_N[7] && E_PAD_OUT[7] == $past(SPI_SCK_OUT)
                && E_PAD_OE_N[5];
    endproperty
    a_spi_master: assert property (p_spi_master)
        else $error("SPI master pins wrong");

    property p_tx_pin;
        CE && serial_ctl[ENSER_BIT]
            |=> !E_PAD_OE_N[0] && E_PAD_OUT[0] == $past(SERIAL_TX_OUT);
    endproperty
    a_tx_pin: assert property (p_tx_pin)
        else $error("transmit pin not driven");

    c_rd_c: cover property (rd_take && idx == IDX_C_DATA);
    c_clk_on: cover property (CE && clock_out_enable ##2 !C_PAD_OE_N[2]);
    c_spi_slave: cover property (serial_ctl == 4'h1);
    c_conv_sel: cover property (rd_take && d_own[0]);
endmodule
`default_nettype wire

// ==== rtl/port_owner_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module port_owner_decode
    import gpio_pkg::*;
(
    // configuration
    input  wire logic [4:0] conv_sel,
    input  wire logic [7:0] presc,
    input  wire logic [3:0] ser_ctl,
    input  wire logic [3:0] els,
    input  wire logic       clk_out_en,
    input  wire logic       mclk,
    // peripheral drive
    input  wire logic       sck_out,
    input  wire logic       mosi_out,
    input  wire logic       miso_out,
    input  wire logic [1:0] tch_out,
    input  wire logic [1:0] tch_oe,
    input  wire logic       tx_out,
    // ownership per pin
    output logic [5:0]      c_own,
    output logic [5:0]      c_pout,
    output logic [7:0]      d_own,
    output logic [7:0]      e_own,
    output logic [7:0]      e_poe,
    output logic [7:0]      e_pout
);
    function automatic logic ext_clk(input logic [2:0] ps);
        return ps == PS_EXT_CLK;
    endfunction

    logic spi_on;
    logic mstr;
    assign spi_on = ser_ctl[SPI_EN_BIT];
    assign mstr = ser_ctl[MSTR_BIT];

    always_comb begin
        c_own = '0;
        c_pout = '0;
        c_own[MCLK_PIN] = clk_out_en;
        c_pout[MCLK_PIN] = mclk;
        d_own = '0;
        for (int i = 0; i < 7; i++) begin
            d_own[i] = conv_sel == CONV_FIRST_CH + 5'(i);
        end
        d_own[TIMER_A_CLK_PIN] |= ext_clk(presc[PS_A_LSB +: 3]);
        d_own[TIMER_B_CLK_PIN] |= ext_clk(presc[PS_B_LSB +: 3]);
        e_own[7] = spi_on;
        e_poe[7] = mstr;
        e_pout[7] = sck_out;
        e_own[6] = spi_on;
        e_poe[6] = mstr;
        e_pout[6] = mosi_out;
        e_own[5] = spi_on;
        e_poe[5] = ~mstr;
        e_pout[5] = miso_out;
        e_own[4] = spi_on & ~(mstr & ~ser_ctl[MODF_BIT]);
        e_poe[4] = 1'b0;
        e_pout[4] = 1'b0;
        e_own[3] = |els[3:2];
        e_poe[3] = tch_oe[1];
        e_pout[3] = tch_out[1];
        e_own[2] = |els[1:0];
        e_poe[2] = tch_oe[0];
        e_pout[2] = tch_out[0];
        e_own[1] = ser_ctl[ENSER_BIT];
        e_poe[1] = 1'b0;
        e_pout[1] = 1'b0;
        e_own[0] = ser_ctl[ENSER_BIT];
        e_poe[0] = 1'b1;
        e_pout[0] = tx_out;
    end
endmodule
`default_nettype wire

// ==== rtl/port_pin_mux.sv ====
`timescale 1ns/10ps
`default_nettype none
module port_pin_mux #(
    parameter int W = 8
) (
    // software state
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    // peripheral ownership
    input  wire logic [W-1:0] own,
    input  wire logic [W-1:0] poe,
    input  wire logic [W-1:0] pout,
    input  wire logic [W-1:0] zero,
    // pad side
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] rd,
    output logic      [W-1:0] drv,
    output logic      [W-1:0] oe_n
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            // direction bit always picks latch on reads, even when owned
            assign rd[i]   = dir[i] ? latch[i] : (zero[i] ? 1'b0 : pin[i]);
            assign drv[i]  = own[i] ? pout[i] : latch[i];
            assign oe_n[i] = own[i] ? ~poe[i] : ~dir[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ==== shared/gpio_pkg.sv ====
`default_nettype none
package gpio_pkg;
    // register word index; byte address is four times the index
    localparam logic [5:0] IDX_C_DATA  = 6'h02;
    localparam logic [5:0] IDX_D_DATA  = 6'h03;
    localparam logic [5:0] IDX_C_DIR   = 6'h06;
    localparam logic [5:0] IDX_D_DIR   = 6'h07;
    localparam logic [5:0] IDX_E_DATA  = 6'h08;
    localparam logic [5:0] IDX_E_DIR   = 6'h0c;
    localparam logic [5:0] IDX_CONV    = 6'h10;
    localparam logic [5:0] IDX_PRESCL  = 6'h11;
    localparam logic [5:0] IDX_SER_CTL = 6'h12;
    localparam logic [5:0] IDX_ELS     = 6'h13;

    localparam int PC_W = 6;
    localparam int PORT_W = 8;

    // field positions
    localparam int CLK_OUT_BIT = 7;
    localparam int MCLK_PIN    = 2;
    localparam int TIMER_A_CLK_PIN = 6;
    localparam int TIMER_B_CLK_PIN = 4;
    localparam int SPI_EN_BIT      = 0;
    localparam int MSTR_BIT    = 1;
    localparam int MODF_BIT    = 2;
    localparam int ENSER_BIT   = 3;
    localparam int PS_A_LSB    = 0;
    localparam int PS_B_LSB    = 4;

    // encodings
    localparam logic [4:0] CONV_FIRST_CH = 5'h08;
    localparam logic [2:0] PS_EXT_CLK    = 3'h7;

    // reset values
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [7:0] RST_OE_N  = 8'hff;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== tb/gpio_ports_c_d_e_pin_logic_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module gpio_ports_c_d_e_pin_logic_test;
    import gpio_pkg::*;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        ack;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dati;
    logic [31:0] dato;
    logic [5:0]  c_in, c_out, c_oe_n;
    logic [7:0]  d_in, d_out, d_oe_n, e_in, e_out, e_oe_n;
    logic [23:0] ext;
    logic [2:0]  sdrv;
    logic [1:0]  tout, toe;
    logic        tx;
    int          fails, check_count;
    logic [7:0]  m [64];

    gpio_ports_cde gpio_ports_cde_i (
        .REF_CLK(clk), .SYS_RST(rst), .CE(1'b1),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
        .C_PAD_IN(c_in), .C_PAD_OUT(c_out), .C_PAD_OE_N(c_oe_n),
        .D_PAD_IN(d_in), .D_PAD_OUT(d_out), .D_PAD_OE_N(d_oe_n),
        .E_PAD_IN(e_in), .E_PAD_OUT(e_out), .E_PAD_OE_N(e_oe_n),
        .SPI_SCK_OUT(sdrv[2]), .SPI_MOSI_OUT(sdrv[1]),
        .SPI_MISO_OUT(sdrv[0]), .TIMER_A_CH_OUT(tout),
        .TIMER_A_CH_OE(toe), .SERIAL_TX_OUT(tx)
    );
    pad_board pad_board_i (
        .c_out(c_out), .c_oe_n(c_oe_n), .d_out(d_out), .d_oe_n(d_oe_n),
        .e_out(e_out), .e_oe_n(e_oe_n), .ext(ext),
        .c_in(c_in), .d_in(d_in), .e_in(e_in)
    );

    //////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dati <= {24'h000000, d};
        // wait for the answer, bounded so a dead slave cannot hang us
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            fails++;
        q = dato[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
        m[idx] = d & (idx == IDX_C_DATA ? 8'h3f :
                      idx == IDX_C_DIR ? 8'hbf : 8'hff);
    endtask

    task automatic rd(input string what, input logic [5:0] idx,
                      input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(what, q, e);
    endtask

    task automatic check_all;
        logic [7:0] cd, dd, ed, s, el, cv, own, pd, pv, xe;
        logic [5:0] xc, co, lm;
        repeat (3) @(posedge clk);
        cd = m[IDX_C_DIR];
        xc = (cd[5:0] & m[IDX_C_DATA][5:0]) | (~cd[5:0] & ext[5:0]);
        co = cd[5:0];
        lm = cd[5:0];
        if (cd[CLK_OUT_BIT]) begin
            co[MCLK_PIN] = 1'b1;
            lm[MCLK_PIN] = 1'b0;
            xc[MCLK_PIN] = 1'b0;
        end
        chk("c drive", {2'b00, ~c_oe_n}, {2'b00, co});
        chk("c out", {2'b00, c_out & lm}, {2'b00, m[2][5:0] & lm});
        rd("c data", IDX_C_DATA, {2'b00, xc});
        rd("c dir", IDX_C_DIR, cd);
        dd = m[IDX_D_DIR];
        cv = m[IDX_CONV];
        own = 8'h00;
        if (cv[4:0] >= CONV_FIRST_CH && cv[4:0] <= CONV_FIRST_CH + 5'h06)
            own[cv[2:0]] = 1'b1;
        if (m[IDX_PRESCL][2:0] == PS_EXT_CLK)
            own[TIMER_A_CLK_PIN] = 1'b1;
        if (m[IDX_PRESCL][6:4] == PS_EXT_CLK)
            own[TIMER_B_CLK_PIN] = 1'b1;
        chk("d drive", ~d_oe_n, dd & ~own);
        chk("d out", d_out & dd & ~own, m[IDX_D_DATA] & dd & ~own);
        xe = (dd & m[IDX_D_DATA]) | (~dd & ~own & ext[15:8]);
        rd("d data", IDX_D_DATA, xe);
        rd("d dir", IDX_D_DIR, dd);
        s = m[IDX_SER_CTL];
        el = m[IDX_ELS];
        own = 8'h00;
        pd = 8'h00;
        pv = 8'h00;
        if (s[SPI_EN_BIT])
            own[7:5] = 3'h7;
        if (s[SPI_EN_BIT] && !(s[MSTR_BIT] && !s[MODF_BIT]))
            own[4] = 1'b1;
        if (s[SPI_EN_BIT] && s[MSTR_BIT])
            {pd[7:6], pv[7:6]} = {2'h3, sdrv[2:1]};
        if (s[SPI_EN_BIT] && !s[MSTR_BIT])
            {pd[5], pv[5]} = {1'b1, sdrv[0]};
        if (s[ENSER_BIT])
            {own[1:0], pd[0], pv[0]} = {3'h7, tx};
        if (el[1:0] != 2'h0)
            {own[2], pd[2], pv[2]} = {1'b1, toe[0], tout[0]};
        if (el[3:2] != 2'h0)
            {own[3], pd[3], pv[3]} = {1'b1, toe[1], tout[1]};
        ed = m[IDX_E_DIR];
        chk("e drive", ~e_oe_n, (ed & ~own) | pd);
        xe = (pd & pv) | (~pd & m[IDX_E_DATA]);
        chk("e out", e_out & ~e_oe_n, xe & ((ed & ~own) | pd));
        xe = (ed & m[IDX_E_DATA]) | (~ed & ((pd & pv) | (~pd & ext[23:16])));
        rd("e data", IDX_E_DATA, xe);
        rd("e dir", IDX_E_DIR, ed);
    endtask

    task automatic step(input logic shared);
        ext <= 24'($urandom);
        sdrv <= 3'($urandom);
        tout <= 2'($urandom);
        toe <= 2'($urandom);
        tx <= 1'($urandom);
        if (shared) begin
            wr(IDX_CONV, 8'($urandom));
            wr(IDX_PRESCL, {1'b0, 3'($urandom_range(7, 5)),
                            1'b0, 3'($urandom_range(7, 5))});
            wr(IDX_SER_CTL, 8'($urandom_range(15, 0)));
            wr(IDX_ELS, 8'($urandom_range(15, 0)));
        end
        // latch before direction so a new output starts at its level
        wr(IDX_C_DATA, 8'($urandom));
        wr(IDX_D_DATA, 8'($urandom));
        wr(IDX_E_DATA, 8'($urandom));
        wr(IDX_C_DIR, 8'($urandom) & (shared ? 8'hff : 8'h7f));
        wr(IDX_D_DIR, 8'($urandom));
        wr(IDX_E_DIR, 8'($urandom));
        check_all;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    //////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test;
    end

    initial begin
        {rst, cyc, stb, we, adr, dati, ext, sdrv, tout, toe, tx} = '0;
        rst = 1'b1;
        sel = 4'hf;
        fails = 0;
        check_count = 0;
        foreach (m[k])
            m[k] = 8'h00;
        void'($urandom(32'hec57c77b));
        repeat (12) @(posedge clk);
        chk("reset c", {2'b00, ~c_oe_n}, 8'h00);
        chk("reset d", ~d_oe_n, 8'h00);
        rst <= 1'b0;
        check_all;
        $display("test reset done");
        for (int i = 0; i < 10; i++)
            step(1'b0);
        $display("test plain pins done");
        for (int i = 0; i < 30; i++)
            step(1'b1);
        $display("test shared pins done");
        wr(6'h3f, 8'hff);
        rd("unmapped", 6'h3f, 8'h00);
        $display("test unmapped done");
        stop_test;
    end
endmodule
`default_nettype wire

// ==== tb/pad_board.sv ====
`timescale 1ns/10ps
`default_nettype none
module pad_board (
    // design pads
    input  wire logic [5:0]  c_out,
    input  wire logic [5:0]  c_oe_n,
    input  wire logic [7:0]  d_out,
    input  wire logic [7:0]  d_oe_n,
    input  wire logic [7:0]  e_out,
    input  wire logic [7:0]  e_oe_n,
    // board sources where no pad drives
    input  wire logic [23:0] ext,
    // levels seen back at the pads
    output logic      [5:0]  c_in,
    output logic      [7:0]  d_in,
    output logic      [7:0]  e_in
);
    // a driving pad wins; an undriven line follows the board source
    assign c_in = (c_out & ~c_oe_n) | (ext[5:0] & c_oe_n);
    assign d_in = (d_out & ~d_oe_n) | (ext[15:8] & d_oe_n);
    assign e_in = (e_out & ~e_oe_n) | (ext[23:16] & e_oe_n);
endmodule
`default_nettype wire
